/* File: pwm_group_pkg.sv */
// constants for the three-channel pwm group
package pwm_group_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] idx_pwm0_control = 8'h20;
  localparam logic [7:0] idx_pwm_group_clock = 8'h21;
  localparam logic [7:0] idx_pwm0_duty_high = 8'h22;
  localparam logic [7:0] idx_pwm0_duty_low = 8'h23;
  localparam logic [7:0] idx_counter_bound_high = 8'h24;
  localparam logic [7:0] idx_counter_bound_low = 8'h25;
  localparam logic [7:0] idx_pwm1_control = 8'h26;
  localparam logic [7:0] idx_pwm1_duty_high = 8'h28;
  localparam logic [7:0] idx_pwm1_duty_low = 8'h29;
  localparam logic [7:0] idx_pwm2_control = 8'h2c;
  localparam logic [7:0] idx_pwm2_duty_high = 8'h2e;
  localparam logic [7:0] idx_pwm2_duty_low = 8'h2f;
  localparam int addr_width = 8;
  localparam int width = 11;
  // bit positions
  localparam int bit_enable = 7;
  localparam int bit_source = 0;
  localparam int bit_status = 6;
  localparam int bit_invert = 5;
  localparam int bit_select = 4;
  localparam int bit_combine = 0;
  localparam int presc_lsb = 4;
  localparam int port_lsb = 1;
  localparam logic [2:0] port_off = 3'h0;
  localparam logic [2:0] port_sel1 = 3'h1;
  localparam logic [2:0] port_sel3 = 3'h3;
  localparam logic [2:0] port_sel4 = 3'h4;
  localparam logic [2:0] port_sel5 = 3'h5;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [10:0] zero11 = 11'h000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

/* File: pwm_group.sv */
// three-channel pwm group with an axi4-lite register slave
`timescale 1ns/10ps
module pwm_group #(
  parameter bit fast_doubled = 1'b0
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // fast internal oscillator, synchronous tick pulses
  input wire logic fast_tick,
  input wire logic fast_tick_double,
  // axi4-lite write address and data
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  output logic port_a_pin0,
  output logic port_a_pin3,
  output logic port_a_pin4,
  output logic port_a_pin5,
  output logic port_b_pin2,
  output logic port_b_pin3,
  output logic port_b_pin4,
  output logic port_b_pin5,
  output logic port_b_pin6,
  output logic port_b_pin7,
  output logic [9:0] pin_oe
);
  typedef enum logic [1:0] {
    wr_idle = 2'b00,
    wr_resp = 2'b01
  } wr_state_t;

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx);
  endfunction

  // eleven-bit value from a high byte and the top bits of a low byte
  function automatic logic [10:0] duty_word(input logic [7:0] high, input logic [7:0] low);
    duty_word = {high, low[7:5]};
  endfunction

  // strict compare keeps a zero duty fully low
  function automatic logic below(input logic [10:0] count, input logic [10:0] limit);
    below = (count < limit);
  endfunction

  // register state
  logic [7:0] ctrl0, ctrl1, ctrl2, clk_reg, bound_high, bound_low;
  logic [7:0] low0, low1, low2;
  logic [10:0] duty0, duty1, duty2;
  logic [10:0] counter;
  logic [6:0] presc_cnt;
  logic raw0, raw1, raw2, half2;
  logic port_out0, port_out1, port_out2;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic aw_held, w_held;
  wr_state_t wr_state;

  // write channel
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [9:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = (wr_state == wr_idle) && have_aw && have_w;
  wire [7:0] wbyte = wd[7:0];
  wire wlane = s_axi_wstrb[0];
  wire we_c0 = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm0_control);
  wire we_clk = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm_group_clock);
  wire we_d0h = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm0_duty_high);
  wire we_d0l = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm0_duty_low);
  wire we_bh = do_write && wlane && hit(wa, pwm_group_pkg::idx_counter_bound_high);
  wire we_bl = do_write && wlane && hit(wa, pwm_group_pkg::idx_counter_bound_low);
  wire we_c1 = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm1_control);
  wire we_d1h = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm1_duty_high);
  wire we_d1l = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm1_duty_low);
  wire we_c2 = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm2_control);
  wire we_d2h = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm2_duty_high);
  wire we_d2l = do_write && wlane && hit(wa, pwm_group_pkg::idx_pwm2_duty_low);
  wire w_mapped = hit(wa, pwm_group_pkg::idx_pwm0_control)
    || hit(wa, pwm_group_pkg::idx_pwm_group_clock)
    || hit(wa, pwm_group_pkg::idx_pwm0_duty_high)
    || hit(wa, pwm_group_pkg::idx_pwm0_duty_low)
    || hit(wa, pwm_group_pkg::idx_counter_bound_high)
    || hit(wa, pwm_group_pkg::idx_counter_bound_low)
    || hit(wa, pwm_group_pkg::idx_pwm1_control)
    || hit(wa, pwm_group_pkg::idx_pwm1_duty_high)
    || hit(wa, pwm_group_pkg::idx_pwm1_duty_low)
    || hit(wa, pwm_group_pkg::idx_pwm2_control)
    || hit(wa, pwm_group_pkg::idx_pwm2_duty_high)
    || hit(wa, pwm_group_pkg::idx_pwm2_duty_low);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 10'h000;
      w_data <= 32'h00000000;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
      end
      aw_held <= do_write ? 1'b0 : have_aw;
      w_held <= do_write ? 1'b0 : have_w;
    end
  end

  // readies pulse while idle with nothing held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (wr_state == wr_idle) && !have_aw && !s_axi_awready;
      s_axi_wready <= (wr_state == wr_idle) && !have_w && !s_axi_wready;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= wr_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwm_group_pkg::resp_okay;
    end else begin
      case (wr_state)
        wr_idle: begin
          if (do_write) begin
            wr_state <= wr_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_mapped ? pwm_group_pkg::resp_okay : pwm_group_pkg::resp_slverr;
          end
        end
        wr_resp: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= wr_idle;
          end
        end
        default: wr_state <= wr_idle;
      endcase
    end
  end

  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0 <= pwm_group_pkg::ctrl_reset;
      ctrl1 <= pwm_group_pkg::ctrl_reset;
      ctrl2 <= pwm_group_pkg::ctrl_reset;
      clk_reg <= pwm_group_pkg::ctrl_reset;
      bound_high <= pwm_group_pkg::ctrl_reset;
      bound_low <= pwm_group_pkg::ctrl_reset;
    end else begin
      if (we_c0) ctrl0 <= wbyte;
      if (we_c1) ctrl1 <= wbyte;
      if (we_c2) ctrl2 <= wbyte;
      if (we_clk) clk_reg <= wbyte;
      if (we_bh) bound_high <= wbyte;
      if (we_bl) bound_low <= wbyte;
    end
  end

  // staged low duty bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low0 <= pwm_group_pkg::ctrl_reset;
      low1 <= pwm_group_pkg::ctrl_reset;
      low2 <= pwm_group_pkg::ctrl_reset;
    end else begin
      if (we_d0l) low0 <= wbyte;
      if (we_d1l) low1 <= wbyte;
      if (we_d2l) low2 <= wbyte;
    end
  end

  // live duty values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty0 <= pwm_group_pkg::zero11;
      duty1 <= pwm_group_pkg::zero11;
      duty2 <= pwm_group_pkg::zero11;
    end else begin
      // low byte is staged; high write commits the full value
      if (we_d0h) duty0 <= duty_word(wbyte, low0);
      if (we_d1h) duty1 <= duty_word(wbyte, low1);
      if (we_d2h) duty2 <= duty_word(wbyte, low2);
    end
  end

  // read channel, one cycle answer
  wire [9:0] ra = s_axi_araddr;
  wire [7:0] st0 = {1'b0, port_out0, ctrl0[5:0]};
  wire [7:0] st1 = {1'b0, port_out1, ctrl1[5:0]};
  wire [7:0] st2 = {1'b0, port_out2, ctrl2[5:0]};
  wire r_c0 = hit(ra, pwm_group_pkg::idx_pwm0_control);
  wire r_c1 = hit(ra, pwm_group_pkg::idx_pwm1_control);
  wire r_c2 = hit(ra, pwm_group_pkg::idx_pwm2_control);
  wire r_wo = hit(ra, pwm_group_pkg::idx_pwm_group_clock)
    || (ra[9:2] >= pwm_group_pkg::idx_pwm0_duty_high
      && ra[9:2] <= pwm_group_pkg::idx_counter_bound_low)
    || hit(ra, pwm_group_pkg::idx_pwm1_duty_high)
    || hit(ra, pwm_group_pkg::idx_pwm1_duty_low)
    || hit(ra, pwm_group_pkg::idx_pwm2_duty_high)
    || hit(ra, pwm_group_pkg::idx_pwm2_duty_low);
  wire [7:0] rbyte = r_c0 ? st0 : r_c1 ? st1 : r_c2 ? st2 : 8'h00;
  wire r_ok = r_c0 || r_c1 || r_c2 || r_wo;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pwm_group_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rbyte};
        s_axi_rresp <= r_ok ? pwm_group_pkg::resp_okay : pwm_group_pkg::resp_slverr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // clock source and prescaler
  wire enable = clk_reg[pwm_group_pkg::bit_enable];
  wire [2:0] presc = clk_reg[pwm_group_pkg::presc_lsb +: 3];
  wire fast_src = fast_doubled ? fast_tick_double : fast_tick;
  wire src_tick = clk_reg[pwm_group_pkg::bit_source] ? fast_src : 1'b1;
  wire [6:0] presc_max = 7'((8'h01 << presc) - 8'h01);
  wire presc_wrap = src_tick && (presc_cnt >= presc_max);
  wire [10:0] bound = {bound_high, bound_low[7:6], 1'b0};
  wire at_bound = counter >= bound;

  // prescaler; a disabled group holds its prescaler, counter and parity at zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      presc_cnt <= 7'h00;
    end else begin
      if (src_tick) presc_cnt <= presc_wrap ? 7'h00 : presc_cnt + 7'h01;
    end
  end

  // shared period counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      counter <= pwm_group_pkg::zero11;
    end else begin
      if (presc_wrap) begin
        counter <= at_bound ? pwm_group_pkg::zero11 : counter + 11'h001;
      end
    end
  end

  // period parity for the divide-by-two output
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      half2 <= 1'b0;
    end else begin
      if (presc_wrap && at_bound) half2 <= ~half2;
    end
  end

  // raw compares
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw0 <= 1'b0;
      raw1 <= 1'b0;
      raw2 <= 1'b0;
    end else begin
      raw0 <= enable && below(counter, duty0);
      raw1 <= enable && below(counter, duty1);
      raw2 <= enable && below(counter, duty2);
    end
  end

  // output selection
  wire sel2 = ctrl2[pwm_group_pkg::bit_select] ? (raw2 && !half2) : raw2;
  wire sel1 = ctrl1[pwm_group_pkg::bit_select] ? raw2 : raw1;
  wire comb0 = ctrl0[pwm_group_pkg::bit_combine] ? (raw0 | raw1) : (raw0 ^ raw1);
  wire sel0 = ctrl0[pwm_group_pkg::bit_select] ? comb0 : raw0;
  assign port_out0 = sel0 ^ ctrl0[pwm_group_pkg::bit_invert];
  assign port_out1 = sel1 ^ ctrl1[pwm_group_pkg::bit_invert];
  assign port_out2 = sel2 ^ ctrl2[pwm_group_pkg::bit_invert];
  wire [2:0] route0 = ctrl0[pwm_group_pkg::port_lsb +: 3];
  wire [2:0] route1 = ctrl1[pwm_group_pkg::port_lsb +: 3];
  wire [2:0] route2 = ctrl2[pwm_group_pkg::port_lsb +: 3];
  wire oe_b5 = route0 == pwm_group_pkg::port_sel1;
  wire oe_a0 = route0 == pwm_group_pkg::port_sel3;
  wire oe_b4 = route0 == pwm_group_pkg::port_sel4;
  wire oe_b6 = route1 == pwm_group_pkg::port_sel1;
  wire oe_a4 = route1 == pwm_group_pkg::port_sel3;
  wire oe_b7 = route1 == pwm_group_pkg::port_sel4;
  wire oe_b3 = route2 == pwm_group_pkg::port_sel1;
  wire oe_a3 = route2 == pwm_group_pkg::port_sel3;
  wire oe_b2 = route2 == pwm_group_pkg::port_sel4;
  wire oe_a5 = route2 == pwm_group_pkg::port_sel5;

  // pin enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= 10'h000;
    end else begin
      pin_oe <= {oe_b7, oe_b6, oe_b5, oe_b4, oe_b3, oe_b2, oe_a5, oe_a4, oe_a3, oe_a0};
    end
  end

  // pin registers; undriven pins rest low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_pin0 <= 1'b0;
      port_a_pin3 <= 1'b0;
      port_a_pin4 <= 1'b0;
      port_a_pin5 <= 1'b0;
      port_b_pin2 <= 1'b0;
      port_b_pin3 <= 1'b0;
      port_b_pin4 <= 1'b0;
      port_b_pin5 <= 1'b0;
      port_b_pin6 <= 1'b0;
      port_b_pin7 <= 1'b0;
    end else begin
      port_a_pin0 <= oe_a0 && port_out0;
      port_b_pin4 <= oe_b4 && port_out0;
      port_b_pin5 <= oe_b5 && port_out0;
      port_a_pin4 <= oe_a4 && port_out1;
      port_b_pin6 <= oe_b6 && port_out1;
      port_b_pin7 <= oe_b7 && port_out1;
      port_a_pin3 <= oe_a3 && port_out2;
      port_a_pin5 <= oe_a5 && port_out2;
      port_b_pin2 <= oe_b2 && port_out2;
      port_b_pin3 <= oe_b3 && port_out2;
    end
  end
endmodule

/* File: pwm_group_asserts.sv */
// concurrent checks on the pwm group's bus and pin ports
`timescale 1ns/10ps
module pwm_group_asserts (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic port_a_pin0,
  input wire logic port_a_pin3,
  input wire logic port_a_pin4,
  input wire logic port_a_pin5,
  input wire logic port_b_pin2,
  input wire logic port_b_pin3,
  input wire logic port_b_pin4,
  input wire logic port_b_pin5,
  input wire logic port_b_pin6,
  input wire logic port_b_pin7,
  input wire logic [9:0] pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // same bit order as pin_oe
  wire logic [9:0] pins = {port_b_pin7, port_b_pin6, port_b_pin5, port_b_pin4, port_b_pin3,
    port_b_pin2, port_a_pin5, port_a_pin4, port_a_pin3, port_a_pin0};
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (both_taken |=> s_axi_bvalid)
    else $error("write answer late");
  refused_zero_a: assert property (s_axi_rvalid && s_axi_rresp == pwm_group_pkg::resp_slverr |->
    s_axi_rdata == 32'h0) else $error("refused read returned data");
  pins_gated_a: assert property ((pins & ~pin_oe) == 10'h0)
    else $error("unrouted pin driven high");
  zero_route_a: assert property ($onehot0({pin_oe[7], pin_oe[6], pin_oe[0]}))
    else $error("channel zero on several pins");
  one_route_a: assert property ($onehot0({pin_oe[9], pin_oe[8], pin_oe[2]}))
    else $error("channel one on several pins");
  two_route_a: assert property ($onehot0({pin_oe[5], pin_oe[4], pin_oe[3], pin_oe[1]}))
    else $error("channel two on several pins");
endmodule
bind pwm_group pwm_group_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pin0,
  .port_a_pin3, .port_a_pin4, .port_a_pin5, .port_b_pin2, .port_b_pin3, .port_b_pin4,
  .port_b_pin5, .port_b_pin6, .port_b_pin7, .pin_oe);

/* File: test_three_channel_pwm_group.sv */
// register-level testbench for the pwm group
`timescale 1ns/10ps
module test_three_channel_pwm_group;
  localparam logic [7:0] c0 = pwm_group_pkg::idx_pwm0_control;
  localparam logic [7:0] c1 = pwm_group_pkg::idx_pwm1_control;
  localparam logic [7:0] c2 = pwm_group_pkg::idx_pwm2_control;
  localparam logic [7:0] ck = pwm_group_pkg::idx_pwm_group_clock;
  localparam logic [1:0] ok = pwm_group_pkg::resp_okay;
  localparam logic [1:0] er = pwm_group_pkg::resp_slverr;
  logic aclk = 0, aresetn = 0, fast_tick = 0, fast_tick_double = 0;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic a0, a3, a4, a5, b2, b3, b4, b5, b6, b7;
  logic [9:0] pin_oe;
  wire logic [9:0] pins = {b7, b6, b5, b4, b3, b2, a5, a4, a3, a0};
  logic [1:0] tick_cnt = 0;
  int n_fail = 0, compares = 0;
  int r_ch[10] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  int r_code[10] = '{1, 3, 4, 1, 3, 4, 1, 3, 4, 5};
  int r_bit[10] = '{7, 0, 6, 8, 2, 9, 5, 1, 4, 3};
  logic [7:0] cidx[3] = '{c0, c1, c2};

  pwm_group uut (.aclk(aclk), .aresetn(aresetn), .fast_tick(fast_tick),
    .fast_tick_double(fast_tick_double), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_pin0(a0), .port_a_pin3(a3), .port_a_pin4(a4), .port_a_pin5(a5), .port_b_pin2(b2),
    .port_b_pin3(b3), .port_b_pin4(b4), .port_b_pin5(b5), .port_b_pin6(b6), .port_b_pin7(b7),
    .pin_oe(pin_oe));

  always #20 aclk = ~aclk;
  // fast oscillator tick every third cycle, double tick every other
  always @(posedge aclk) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    fast_tick <= (tick_cnt == 2'h2);
    fast_tick_double <= ~fast_tick_double;
  end

  task close_out;
    $display("mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] eresp);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, eresp});
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] eresp);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, {24'h0, d});
        chk({30'h0, rresp}, {30'h0, eresp});
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // high cycles of one pin over n cycles
  task meas(input int b, input int n, input int e);
    logic [31:0] c;
    c = 0;
    repeat (n) begin
      @(posedge aclk);
      c = c + pins[b];
    end
    chk(c, e);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(c0, 8'h00, ok);
    rd(c2, 8'h00, ok);
    rd(pwm_group_pkg::idx_pwm0_duty_high, 8'h00, ok);
    rd(8'h27, 8'h00, er);
    wr(8'h27, 8'hff, er);
    for (int i = 0; i < 10; i++) begin
      wr(cidx[r_ch[i]], {4'h0, r_code[i][2:0], 1'b0}, ok);
      repeat (3) @(posedge aclk);
      chk({22'h0, pin_oe}, {22'h0, 10'h1 << r_bit[i]});
      wr(cidx[r_ch[i]], 8'h00, ok);
    end
    wr(c0, 8'h22, ok);
    rd(c0, 8'h62, ok);
    wr(c0, 8'h02, ok);
    // bound 8: period of nine ticks
    wr(pwm_group_pkg::idx_counter_bound_low, 8'h00, ok);
    wr(pwm_group_pkg::idx_counter_bound_high, 8'h01, ok);
    wr(pwm_group_pkg::idx_pwm0_duty_low, 8'h80, ok);
    wr(pwm_group_pkg::idx_pwm0_duty_high, 8'h00, ok);
    wr(pwm_group_pkg::idx_pwm1_duty_low, 8'hc0, ok);
    wr(pwm_group_pkg::idx_pwm1_duty_high, 8'h00, ok);
    wr(pwm_group_pkg::idx_pwm2_duty_low, 8'h40, ok);
    wr(pwm_group_pkg::idx_pwm2_duty_high, 8'h00, ok);
    meas(7, 30, 0);
    wr(ck, 8'h80, ok);
    repeat (20) @(posedge aclk);
    meas(7, 90, 40);
    wr(pwm_group_pkg::idx_pwm0_duty_low, 8'he0, ok);
    repeat (12) @(posedge aclk);
    meas(7, 90, 40);
    wr(pwm_group_pkg::idx_pwm0_duty_high, 8'h00, ok);
    repeat (12) @(posedge aclk);
    meas(7, 90, 70);
    wr(pwm_group_pkg::idx_pwm0_duty_low, 8'h80, ok);
    wr(pwm_group_pkg::idx_pwm0_duty_high, 8'h00, ok);
    wr(c0, 8'h22, ok);
    repeat (12) @(posedge aclk);
    meas(7, 90, 50);
    wr(c0, 8'h12, ok);
    repeat (12) @(posedge aclk);
    meas(7, 90, 20);
    wr(c0, 8'h13, ok);
    repeat (12) @(posedge aclk);
    meas(7, 90, 60);
    wr(c0, 8'h02, ok);
    for (int p = 0; p < 8; p++) begin
      wr(ck, {1'b1, 3'(p), 4'h0}, ok);
      repeat (9 * (1 << p) + 12) @(posedge aclk);
      meas(7, 9 * (1 << p), 4 << p);
    end
    wr(ck, 8'h81, ok);
    repeat (40) @(posedge aclk);
    meas(7, 54, 24);
    wr(ck, 8'h80, ok);
    wr(c1, 8'h12, ok);
    repeat (20) @(posedge aclk);
    meas(8, 90, 20);
    wr(c2, 8'h12, ok);
    repeat (40) @(posedge aclk);
    meas(5, 90, 10);
    wr(ck, 8'h00, ok);
    repeat (5) @(posedge aclk);
    meas(7, 30, 0);
    // mid-run reset clears a written control register
    wr(c0, 8'h22, ok);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(c0, 8'h00, ok);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    close_out;
  end
endmodule
